// ==== design/temp_alert_pkg.sv ====
// Constants and carriers for the temperature alert and standby block
`default_nettype none
package temp_alert_pkg;
    localparam logic [6:0] alert_response_addr   = 7'h0C;
    localparam logic [7:0] one_shot_offset       = 8'h0F;
    localparam int         standby_bit           = 6;
    localparam int         open_diode_bit        = 2;
    localparam logic [7:0] short_fault_code      = 8'h80;
    localparam logic [7:0] low_limit_min         = 8'h80;
    localparam int         conv_cycles           = 16;
    localparam logic [7:0] status_reset          = 8'h00;
    // Address table, index = strap_low*3 + strap_high (0 = gnd, 1 = open, 2 = vdd)
    localparam logic [6:0] addr_table [9] = '{7'h18, 7'h19, 7'h1A, 7'h29, 7'h2A, 7'h2B, 7'h4C, 7'h4D, 7'h4E};

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] offset;
        logic [7:0] data;
    } reg_access_t;

    typedef struct packed {
        logic [7:0] local_high;
        logic [7:0] local_low;
        logic [7:0] remote_high;
        logic [7:0] remote_low;
    } limits_t;
endpackage
`default_nettype wire

// ==== design/arbitration_tx.sv ====
// Alert response byte sender with wired-AND bit arbitration
`default_nettype none
module arbitration_tx
    import temp_alert_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [6:0] own_address,
    input  wire logic       bit_strobe,
    input  wire logic       line_in,
    output logic            drive_low,
    output logic            busy,
    output logic            won,
    output logic            lost
);
    typedef enum logic [1:0] {idle, send, done} tx_state_t;
    tx_state_t  state;
    tx_state_t  next_state;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic [3:0] count;
    logic [3:0] next_count;
    logic       next_won;
    logic       next_lost;

    always_comb begin
        next_state = state;
        next_shift = shift;
        next_count = count;
        next_won   = 1'b0;
        next_lost  = 1'b0;
        case (state)
            idle: begin
                if (start) begin
                    next_state = send;
                    next_shift = {own_address, 1'b1};
                    next_count = 4'h0;
                end
            end
            send: begin
                if (bit_strobe) begin
                    // Released one but bus low: a lower address won
                    if (shift[7] && !line_in) begin
                        next_lost  = 1'b1;
                        next_state = idle;
                    end else if (count == 4'h7) begin
                        next_won   = 1'b1;
                        next_state = idle;
                    end else begin
                        next_shift = {shift[6:0], 1'b1};
                        next_count = count + 4'h1;
                    end
                end
            end
            default: next_state = idle;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= idle;
            shift <= 8'hFF;
            count <= 4'h0;
            won   <= 1'b0;
            lost  <= 1'b0;
        end else begin
            state <= next_state;
            shift <= next_shift;
            count <= next_count;
            won   <= next_won;
            lost  <= next_lost;
        end
    end

    assign drive_low = (state == send) && !shift[7];
    assign busy      = (state == send);

    chk_loser_releases: assert property (@(posedge clock) disable iff (rst)
        lost |-> !drive_low) else $error("Loser still drives the line");
endmodule
`default_nettype wire

// ==== design/temp_alert_standby.sv ====
// Alert, standby, one-shot and sensor fault logic of a two-channel temperature monitor
`default_nettype none
module temp_alert_standby
    import temp_alert_pkg::*;
#(
    parameter int conversion_cycles = conv_cycles
)(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        standby_input_n,
    input  wire logic [1:0]  address_strap_low,
    input  wire logic [1:0]  address_strap_high,
    input  wire reg_access_t reg_access,
    input  wire logic [7:0]  config_reg,
    input  wire limits_t     limits,
    input  wire logic [7:0]  local_adc,
    input  wire logic [7:0]  remote_adc,
    input  wire logic        remote_underrange,
    input  wire logic        open_diode_comp,
    input  wire logic        ara_request,
    input  wire logic        ara_bit_strobe,
    input  wire logic        sda_in,
    input  wire logic        alert_in,
    output logic             sda_out,
    output logic             sda_oe,
    output logic             alert_out,
    output logic             alert_oe,
    output logic [6:0]       device_address,
    output logic             ara_ack,
    output logic [7:0]       local_value,
    output logic [7:0]       remote_value,
    output logic [7:0]       status,
    output logic             converting,
    output logic             standby
);
    initial begin
        if (conversion_cycles < 2 || conversion_cycles > 65535) begin
            $error("conversion_cycles out of range");
        end
    end

    typedef enum logic [1:0] {conv_idle, conv_run} conv_state_t;
    conv_state_t state;
    conv_state_t next_state;
    logic [15:0] cycles;
    logic [15:0] next_cycles;
    logic        one_shot_pending;
    logic        next_one_shot_pending;
    logic        strap_taken;
    logic [6:0]  next_device_address;
    logic [7:0]  next_local_value;
    logic [7:0]  next_remote_value;
    logic [7:0]  next_status;
    logic        alert_latch;
    logic        next_alert_latch;
    logic        next_alert_oe;
    logic        next_ara_ack;
    logic        next_sda_oe;
    logic        next_converting;
    logic        next_standby;
    logic        tx_drive_low;
    logic        tx_busy;
    logic        tx_won;
    logic        tx_lost;
    logic        sw_standby;
    logic        cause;
    logic [7:0]  remote_result;

    function automatic logic out_of_limit(input logic [7:0] v, input logic [7:0] hi, input logic [7:0] lo);
        // Signed compare; equal to low limit is fine
        out_of_limit = ($signed(v) > $signed(hi)) || ($signed(v) < $signed(lo));
    endfunction

    function automatic logic [3:0] strap_index(input logic [1:0] lo, input logic [1:0] hi);
        logic [3:0] l;
        logic [3:0] h;
        l = (lo > 2'd2) ? 4'd2 : {2'b00, lo};
        h = (hi > 2'd2) ? 4'd2 : {2'b00, hi};
        strap_index = 4'((l * 4'd3) + h);
    endfunction

    assign sw_standby    = config_reg[standby_bit];
    assign remote_result = remote_underrange ? short_fault_code : remote_adc;
    // Equal-to-minimum low limit cannot be undershot, so a shorted channel is silent
    assign cause = out_of_limit(local_value, limits.local_high, limits.local_low)
                 || out_of_limit(remote_value, limits.remote_high, limits.remote_low)
                 || status[open_diode_bit];

    always_comb begin
        next_state            = state;
        next_cycles           = cycles;
        next_local_value      = local_value;
        next_remote_value     = remote_value;
        next_status           = status;
        next_one_shot_pending = one_shot_pending;
        next_standby          = !standby_input_n || sw_standby;
        // One-shot write latches only a request, no data
        if (reg_access.write && reg_access.offset == one_shot_offset && standby_input_n && sw_standby) begin
            next_one_shot_pending = 1'b1;
        end
        if (!standby_input_n) begin
            next_one_shot_pending = 1'b0;
        end
        case (state)
            conv_idle: begin
                if (standby_input_n && (!sw_standby || one_shot_pending)) begin
                    next_state            = conv_run;
                    next_cycles           = 16'(conversion_cycles - 1);
                    next_one_shot_pending = 1'b0;
                    next_status[open_diode_bit] = open_diode_comp;
                end
            end
            conv_run: begin
                // Standby pin aborts; software standby lets a one-shot finish
                if (!standby_input_n || (sw_standby && !standby)) begin
                    next_state = conv_idle;
                end else if (cycles == 16'h0000) begin
                    next_state        = conv_idle;
                    next_local_value  = local_adc;
                    next_remote_value = remote_result;
                end else begin
                    next_cycles = cycles - 16'h0001;
                end
            end
            default: next_state = conv_idle;
        endcase
        next_converting = (next_state == conv_run);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state            <= conv_idle;
            cycles           <= 16'h0000;
            local_value      <= 8'h00;
            remote_value     <= 8'h00;
            status           <= status_reset;
            one_shot_pending <= 1'b0;
            converting       <= 1'b0;
            standby          <= 1'b0;
        end else begin
            state            <= next_state;
            cycles           <= next_cycles;
            local_value      <= next_local_value;
            remote_value     <= next_remote_value;
            status           <= next_status;
            one_shot_pending <= next_one_shot_pending;
            converting       <= next_converting;
            standby          <= next_standby;
        end
    end

    // Strap capture: taken once after reset release, then frozen
    always_comb begin
        next_device_address = device_address;
        if (!strap_taken) begin
            next_device_address = addr_table[strap_index(address_strap_low, address_strap_high)];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            strap_taken    <= 1'b0;
            device_address <= 7'h00;
        end else begin
            strap_taken    <= 1'b1;
            device_address <= next_device_address;
        end
    end

    arbitration_tx u_tx (
        .clock       (clock),
        .rst         (rst),
        .start       (ara_request && alert_latch && !tx_busy),
        .own_address (device_address),
        .bit_strobe  (ara_bit_strobe),
        .line_in     (sda_in),
        .drive_low   (tx_drive_low),
        .busy        (tx_busy),
        .won         (tx_won),
        .lost        (tx_lost)
    );

    // Alert latch: a new cause wins over the answer-release in the same cycle
    always_comb begin
        next_alert_latch = alert_latch;
        if (tx_won) begin
            next_alert_latch = 1'b0;
        end
        if (cause) begin
            next_alert_latch = 1'b1;
        end
        next_alert_oe = next_alert_latch;
        next_ara_ack  = ara_request && alert_latch && !tx_busy;
        next_sda_oe   = tx_drive_low;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            alert_latch <= 1'b0;
            alert_oe    <= 1'b0;
            ara_ack     <= 1'b0;
            sda_oe      <= 1'b0;
            sda_out     <= 1'b0;
            alert_out   <= 1'b0;
        end else begin
            alert_latch <= next_alert_latch;
            alert_oe    <= next_alert_oe;
            ara_ack     <= next_ara_ack;
            sda_oe      <= next_sda_oe;
            sda_out     <= 1'b0;
            alert_out   <= 1'b0;
        end
    end

    chk_alert_follows_cause: assert property (@(posedge clock) disable iff (rst)
        cause |=> alert_oe) else $error("Alert not raised for cause");
    chk_alert_never_high: assert property (@(posedge clock) disable iff (rst)
        alert_out == 1'b0 && sda_out == 1'b0) else $error("Open drain driven high");
    chk_ara_ack_alerting: assert property (@(posedge clock) disable iff (rst)
        ara_ack |-> $past(alert_latch)) else $error("Ack without alert");
    chk_release_needs_clear: assert property (@(posedge clock) disable iff (rst)
        $fell(alert_latch) |-> $past(tx_won) && !$past(cause)) else $error("Alert released early");
    chk_standby_follows: assert property (@(posedge clock) disable iff (rst)
        ##1 standby == $past(!standby_input_n || sw_standby)) else $error("Standby wrong");
    chk_abort_keeps_value: assert property (@(posedge clock) disable iff (rst)
        (state == conv_run && !standby_input_n) |=> $stable(remote_value)) else $error("Value written on abort");
    chk_pin_blocks_conv: assert property (@(posedge clock) disable iff (rst)
        (state == conv_idle && !standby_input_n) |=> state == conv_idle) else $error("Conversion in pin standby");
    chk_open_diode_sample: assert property (@(posedge clock) disable iff (rst)
        (state == conv_idle && next_state == conv_run) |=> status[open_diode_bit] == $past(open_diode_comp))
        else $error("Open diode not sampled");
    chk_strap_frozen: assert property (@(posedge clock) disable iff (rst)
        $past(strap_taken) |-> $stable(device_address)) else $error("Address changed");

    // Answer path: request taken, then acknowledge with the sender loaded
    sequence ara_taken_s;
        ara_request && alert_latch && !tx_busy;
    endsequence

    sequence ara_answered_s;
        ara_ack && tx_busy;
    endsequence

    chk_ara_answer: assert property (@(posedge clock) disable iff (rst)
        ara_taken_s |=> ara_answered_s)
        else $error("Alert response read not answered");

    chk_ara_refused: assert property (@(posedge clock) disable iff (rst)
        (ara_request && !alert_latch) |=> !ara_ack)
        else $error("Answered without alert");

    // Data line enable lags the sender by one register stage
    chk_sda_follows_tx: assert property (@(posedge clock) disable iff (rst)
        sda_oe == $past(tx_drive_low))
        else $error("Data line enable not following sender");

    chk_loser_quiet: assert property (@(posedge clock) disable iff (rst)
        tx_lost |=> !sda_oe)
        else $error("Loser keeps pulling data line");

    // A standing cause keeps the alert whatever the answer did
    chk_alert_holds: assert property (@(posedge clock) disable iff (rst)
        (alert_latch && cause) |=> alert_latch)
        else $error("Alert dropped with cause present");

    chk_one_shot_refused: assert property (@(posedge clock) disable iff (rst)
        (reg_access.write && reg_access.offset == one_shot_offset && !standby_input_n) |=> !one_shot_pending)
        else $error("One-shot taken in pin standby");

    chk_one_shot_taken: assert property (@(posedge clock) disable iff (rst)
        (reg_access.write && reg_access.offset == one_shot_offset && standby_input_n && sw_standby)
        |=> (one_shot_pending || converting))
        else $error("One-shot lost in software standby");

    chk_underrange_code: assert property (@(posedge clock) disable iff (rst)
        (state == conv_run && cycles == 16'h0000 && standby_input_n && !(sw_standby && !standby)
         && remote_underrange) |=> remote_value == short_fault_code)
        else $error("Fault code not reported");

    // Idle converter never touches the value registers
    chk_idle_keeps_values: assert property (@(posedge clock) disable iff (rst)
        state == conv_idle |=> ($stable(local_value) && $stable(remote_value)))
        else $error("Value written while idle");

    chk_sw_standby_idle: assert property (@(posedge clock) disable iff (rst)
        (state == conv_idle && sw_standby && !one_shot_pending) |=> state == conv_idle)
        else $error("Conversion started in software standby");
endmodule
`default_nettype wire

// ==== test/alert_host_model.sv ====
// Bus host model that services the shared alert line with response reads
`default_nettype none
module alert_host_model (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       go,
    input  wire logic       alert_line,
    input  wire logic       sda_line,
    output logic            ara_request,
    output logic            ara_bit_strobe,
    output logic [3:0]      bit_index,
    output logic [7:0]      last_byte,
    output logic [7:0]      reads
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] shift;
    initial begin
        ara_request = 1'b0;
        ara_bit_strobe = 1'b0;
        bit_index = 4'h8;
        last_byte = 8'h00;
        reads = 8'h00;
        shift = 8'h00;
        forever begin
            @(posedge clock);
            // Keeps reading while the shared line stays low
            if (!rst && go && !alert_line) begin
                #1 ara_request = 1'b1;
                @(posedge clock);
                #1 ara_request = 1'b0;
                repeat (3) @(posedge clock);
                for (int i = 0; i < 8; i++) begin
                    #1 bit_index = 4'(i);
                    repeat (2) @(posedge clock);
                    #1 ara_bit_strobe = 1'b1;
                    // Line settled since the last shift; sample ahead of the strobe edge
                    shift = {shift[6:0], sda_line};
                    @(posedge clock);
                    #1 ara_bit_strobe = 1'b0;
                end
                bit_index = 4'h8;
                last_byte = shift;
                reads = reads + 8'h01;
                repeat (4) @(posedge clock);
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/temp_alert_standby_test.sv ====
// Testbench for the alert, standby and sensor fault logic
`default_nettype none
module temp_alert_standby_test import temp_alert_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int cc = 4;
    logic        clock = 1'b0, rst = 1'b1, standby_input_n_n = 1'b1, odc = 1'b0, under = 1'b0, go = 1'b0, rival_on = 1'b0;
    logic [1:0]  s_lo = 2'h2, s_hi = 2'h0;
    reg_access_t acc = '0;
    logic [7:0]  cfg = 8'h00, ladc = 8'h20, radc = 8'h21;
    limits_t     lim = '{8'h50, 8'h10, 8'h50, 8'h10};
    logic        ara_req, ara_strobe, sda_in, alert_line, sda_out, sda_oe, alert_out, alert_oe, ara_ack;
    logic        converting, standby;
    logic [6:0]  device_address;
    logic [7:0]  local_value, remote_value, status, last_byte, reads;
    logic [3:0]  bit_index;
    int          n_mismatch = 0, samples_checked = 0, n_ack = 0;
    // Acknowledge pulses counted away from the launching edge
    always @(negedge clock) if (ara_ack === 1'b1) n_ack++;
    // Both lines have pull-ups; a rival at address zero pulls the address bits low
    assign sda_in = !(sda_oe || (rival_on && bit_index < 4'h7));
    assign alert_line = !alert_oe;
    always #25 clock = ~clock;
    temp_alert_standby #(.conversion_cycles(cc)) dut (.clock(clock), .rst(rst), .standby_input_n(standby_input_n_n),
        .address_strap_low(s_lo), .address_strap_high(s_hi), .reg_access(acc), .config_reg(cfg), .limits(lim),
        .local_adc(ladc), .remote_adc(radc), .remote_underrange(under), .open_diode_comp(odc),
        .ara_request(ara_req), .ara_bit_strobe(ara_strobe), .sda_in(sda_in), .alert_in(alert_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe),
        .device_address(device_address), .ara_ack(ara_ack), .local_value(local_value),
        .remote_value(remote_value), .status(status), .converting(converting), .standby(standby));
    alert_host_model host (.clock(clock), .rst(rst), .go(go), .alert_line(alert_line), .sda_line(sda_in),
        .ara_request(ara_req), .ara_bit_strobe(ara_strobe), .bit_index(bit_index), .last_byte(last_byte),
        .reads(reads));
    task results;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task check(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task overrun;
        n_mismatch++;
        $display("mismatch wait expected completion seen none");
        results();
    endtask
    task tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Counts finished conversions, so a stuck converter cannot hang the run
    task conv_done(input int k);
        int n, seen;
        logic prev;
        n = 0;
        seen = 0;
        prev = converting;
        while (seen < k && n < 400) begin
            tick(1);
            if (prev === 1'b1 && converting === 1'b0) seen++;
            prev = converting;
            n++;
        end
        if (seen < k) overrun();
        tick(2);
    endtask
    task serve_once;
        logic [7:0] r0;
        int n;
        r0 = reads;
        go = 1'b1;
        n = 0;
        while (reads === r0 && n < 200) begin
            tick(1);
            n++;
        end
        go = 1'b0;
        if (n >= 200) overrun();
    endtask
    task serve_until_release;
        int n;
        go = 1'b1;
        n = 0;
        while (alert_oe !== 1'b0 && n < 600) begin
            tick(1);
            n++;
        end
        go = 1'b0;
        if (n >= 600) overrun();
    endtask
    task one_shot;
        acc.offset = 8'h0F;
        acc.data = 8'hAA;
        acc.write = 1'b1;
        tick(1);
        acc.write = 1'b0;
    endtask
    initial begin
        int n;
        tick(3);
        rst = 1'b0;
        tick(2);
        check("device_address", 8'h4C, {1'b0, device_address});
        s_lo = 2'h0;
        s_hi = 2'h1;
        conv_done(2);
        check("device_address", 8'h4C, {1'b0, device_address});
        check("local_value", 8'h20, local_value);
        serve_until_release();
        check("ara_byte", 8'h99, last_byte);
        check("alert_oe", 8'h00, {7'h0, alert_oe});
        ladc = 8'h10;
        conv_done(2);
        check("alert_oe", 8'h00, {7'h0, alert_oe});
        ladc = 8'h0F;
        conv_done(2);
        check("alert_oe", 8'h01, {7'h0, alert_oe});
        check("alert_out", 8'h00, {7'h0, alert_out});
        serve_once();
        check("ara_byte", 8'h99, last_byte);
        ladc = 8'h20;
        conv_done(2);
        check("alert_oe", 8'h01, {7'h0, alert_oe});
        serve_until_release();
        check("ara_byte", 8'h99, last_byte);
        radc = 8'h60;
        conv_done(2);
        check("alert_oe", 8'h01, {7'h0, alert_oe});
        rival_on = 1'b1;
        serve_once();
        rival_on = 1'b0;
        check("ara_byte", 8'h01, last_byte);
        check("alert_oe", 8'h01, {7'h0, alert_oe});
        radc = 8'h21;
        conv_done(2);
        serve_until_release();
        check("ara_byte", 8'h99, last_byte);
        under = 1'b1;
        conv_done(2);
        check("remote_value", 8'h80, remote_value);
        check("alert_oe", 8'h01, {7'h0, alert_oe});
        lim.remote_low = 8'h80;
        conv_done(2);
        serve_until_release();
        check("alert_oe", 8'h00, {7'h0, alert_oe});
        under = 1'b0;
        conv_done(2);
        n = 0;
        while (converting !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        tick(1);
        radc = 8'h33;
        cfg = 8'h40;
        tick(2 * cc);
        check("standby", 8'h01, {7'h0, standby});
        check("converting", 8'h00, {7'h0, converting});
        check("remote_value", 8'h21, remote_value);
        one_shot();
        conv_done(1);
        check("remote_value", 8'h33, remote_value);
        tick(2 * cc);
        check("converting", 8'h00, {7'h0, converting});
        check("standby", 8'h01, {7'h0, standby});
        standby_input_n_n = 1'b0;
        radc = 8'h44;
        one_shot();
        tick(2 * cc);
        check("converting", 8'h00, {7'h0, converting});
        check("remote_value", 8'h33, remote_value);
        cfg = 8'h00;
        odc = 1'b1;
        tick(2);
        check("standby", 8'h01, {7'h0, standby});
        standby_input_n_n = 1'b1;
        tick(2);
        check("standby", 8'h00, {7'h0, standby});
        conv_done(1);
        check("status", 8'h04, status & 8'h04);
        check("alert_oe", 8'h01, {7'h0, alert_oe});
        check("sda_out", 8'h00, {7'h0, sda_out});
        check("ara_ack", reads, 8'(n_ack));
        results();
    end
endmodule
`default_nettype wire
